// ### design/eep_dev.sv
// EEPROM end of the two-wire link: protocol engine, page buffer, array
`timescale 1ns/10ps
module eep_dev
  import eep_pkg::*;
#(
  parameter int unsigned WR_CYCLES = WR_CYC                   // Write cycle length
) (
  input  wire logic clk,                                      // System clock
  input  wire logic resetn,                                   // Async reset, active low
  input  wire logic wp,                                       // Write protect pin
  output logic      busy,                                     // Write cycle running
  eep_link_if.slave link                                      // Two-wire bus
);

  // ****************************************************************
  // Types and storage
  // ****************************************************************
  typedef enum logic [4:0] {
    S_IDLE = 5'h01,                                           // Not addressed
    S_RX   = 5'h02,                                           // Receiving a byte
    S_ACK  = 5'h04,                                           // Driving acknowledge
    S_TX   = 5'h08,                                           // Sending a byte
    S_RACK = 5'h10                                            // Reading master ack
  } eep_dst_t;

  typedef enum logic [2:0] {
    P_CTRL = 3'h1,                                            // Control byte
    P_ADDR = 3'h2,                                            // Word address byte
    P_DATA = 3'h4                                             // Data bytes
  } eep_phase_t;

  localparam int WCW = $clog2(WR_CYCLES + 1);                 // Write counter width

  eep_dst_t              state_q;                             // Protocol state
  eep_phase_t            phase_q;                             // Byte position in frame
  logic [3:0]            bit_q;                               // Bit counter
  logic [7:0]            shr_q;                               // Receive shifter
  logic [7:0]            tx_q;                                // Transmit shifter
  logic                  rw_q;                                // Direction from control
  logic                  mack_q;                              // Master acknowledged
  logic                  oe_q;                                // Pulling SDA low
  logic [ADDR_W-1:0]     ptr_q;                               // Address pointer
  logic [7:0]            page_q [PAGE_DEPTH];                 // Page buffer
  logic [PAGE_DEPTH-1:0] pval_q;                              // Buffer entries filled
  logic                  busy_q;                              // Write cycle running
  logic [WCW-1:0]        wcnt_q;                              // Write cycle counter
  logic [7:0]            mem [MEM_DEPTH];                     // Memory array
  logic [2:0]            scl_sy_q;                            // SCL sync and history
  logic [2:0]            sda_sy_q;                            // SDA sync and history
  logic [1:0]            wp_sy_q;                             // WP sync

  // ****************************************************************
  // Pin synchronisers and bus events
  // ****************************************************************
  // Two flops per pin, a third stage on SCL and SDA for edge history
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      scl_sy_q <= 3'h7;
      sda_sy_q <= 3'h7;
      wp_sy_q  <= 2'h3;
    end else begin
      scl_sy_q <= {scl_sy_q[1:0], link.scl};
      sda_sy_q <= {sda_sy_q[1:0], link.sda};
      wp_sy_q  <= {wp_sy_q[0], wp};
    end
  end

  logic scl_rise;                                             // SCL rising edge
  logic scl_fall;                                             // SCL falling edge
  logic scl_hi;                                               // SCL high two samples
  logic start_det;                                            // START seen
  logic stop_det;                                             // STOP seen
  logic rx_done;                                              // Eighth bit taken, SCL fell
  logic tx_load;                                              // Load a byte to send
  logic commit;                                               // Write cycle ends

  assign scl_rise  = scl_sy_q[1] & ~scl_sy_q[2];
  assign scl_fall  = ~scl_sy_q[1] & scl_sy_q[2];
  assign scl_hi    = scl_sy_q[1] & scl_sy_q[2];
  assign start_det = scl_hi & ~sda_sy_q[1] & sda_sy_q[2];
  assign stop_det  = scl_hi & sda_sy_q[1] & ~sda_sy_q[2];
  assign rx_done   = (state_q == S_RX) & scl_fall & (bit_q == 4'h8);
  assign tx_load   = scl_fall & (((state_q == S_ACK) & rw_q & (phase_q == P_CTRL))
                                 | ((state_q == S_RACK) & mack_q));
  assign commit    = busy_q & (wcnt_q == '0);

  // ****************************************************************
  // Protocol state machine
  // ****************************************************************
  // Acts on synchronised SCL edges and on START or STOP, so SDA moves only after SCL falls
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= S_IDLE;
      phase_q <= P_CTRL;
      bit_q   <= 4'h0;
      rw_q    <= 1'b0;
      mack_q  <= 1'b0;
      oe_q    <= 1'b0;
      tx_q    <= 8'h00;
    end else if (start_det) begin
      state_q <= S_RX;
      phase_q <= P_CTRL;
      bit_q   <= 4'h0;
      oe_q    <= 1'b0;
    end else if (stop_det) begin
      state_q <= S_IDLE;
      oe_q    <= 1'b0;
    end else begin
      unique case (state_q)
        S_IDLE: begin
          oe_q <= 1'b0;
        end
        S_RX: begin
          if (scl_rise) begin
            bit_q <= bit_q + 4'h1;
          end else if (rx_done) begin
            if (phase_q == P_CTRL) begin
              rw_q <= shr_q[0];
            end
            // Wrong code or busy: stay silent until next START
            if ((phase_q == P_CTRL) && ((shr_q[7:4] != DEV_CODE) || busy_q)) begin
              state_q <= S_IDLE;
            end else begin
              state_q <= S_ACK;
              oe_q    <= 1'b1;
            end
          end
        end
        S_ACK: begin
          if (tx_load) begin
            state_q <= S_TX;
            bit_q   <= 4'h0;
            tx_q    <= mem[ptr_q];
            oe_q    <= ~mem[ptr_q][7];
          end else if (scl_fall) begin
            state_q <= S_RX;
            bit_q   <= 4'h0;
            oe_q    <= 1'b0;
            phase_q <= (phase_q == P_CTRL) ? P_ADDR : P_DATA;
          end
        end
        S_TX: begin
          if (scl_fall) begin
            bit_q <= bit_q + 4'h1;
            if (bit_q == 4'h7) begin
              state_q <= S_RACK;
              oe_q    <= 1'b0;                                  // Release for master ack
            end else begin
              tx_q <= {tx_q[6:0], 1'b0};
              oe_q <= ~tx_q[6];
            end
          end
        end
        S_RACK: begin
          if (scl_rise) begin
            mack_q <= ~sda_sy_q[1];
          end else if (tx_load) begin
            state_q <= S_TX;
            bit_q   <= 4'h0;
            tx_q    <= mem[ptr_q];
            oe_q    <= ~mem[ptr_q][7];
          end else if (scl_fall) begin
            state_q <= S_IDLE;
            oe_q    <= 1'b0;
          end
        end
      endcase
    end
  end

  // Receive shifter, MSB first
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      shr_q <= 8'h00;
    end else if ((state_q == S_RX) && scl_rise) begin
      shr_q <= {shr_q[6:0], sda_sy_q[1]};
    end
  end

  // ****************************************************************
  // Address pointer
  // ****************************************************************
  // Word address load, page wrap on writes, full wrap on reads
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ptr_q <= PTR_RST;
    end else if (rx_done && (phase_q == P_ADDR)) begin
      ptr_q <= shr_q;
    end else if (rx_done && (phase_q == P_DATA)) begin
      ptr_q[2:0] <= ptr_q[2:0] + 3'h1;
    end else if (tx_load) begin
      ptr_q <= ptr_q + 8'h01;
    end
  end

  // ****************************************************************
  // Page buffer and write cycle
  // ****************************************************************
  // Data bytes land by low pointer bits; later bytes overwrite earlier
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pval_q <= '0;
      for (int i = 0; i < PAGE_DEPTH; i++) begin
        page_q[i] <= 8'h00;
      end
    end else if (commit || (start_det && !busy_q)) begin
      pval_q <= '0;                                             // Uncommitted data dropped
    end else if (rx_done && (phase_q == P_DATA)) begin
      page_q[ptr_q[2:0]] <= shr_q;
      pval_q[ptr_q[2:0]] <= 1'b1;
    end
  end

  // STOP after data starts the self-timed cycle unless protected
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      busy_q <= 1'b0;
      wcnt_q <= '0;
    end else if (busy_q) begin
      wcnt_q <= wcnt_q - 1'b1;
      if (wcnt_q == '0) begin
        busy_q <= 1'b0;
      end
    end else if (stop_det && (pval_q != '0) && !wp_sy_q[1]) begin
      busy_q <= 1'b1;
      wcnt_q <= WCW'(WR_CYCLES - 1);
    end
  end

  // Array update of every filled buffer entry within the page
  always_ff @(posedge clk) begin
    if (commit) begin
      for (int i = 0; i < PAGE_DEPTH; i++) begin
        if (pval_q[i]) begin
          mem[{ptr_q[7:3], 3'(i)}] <= page_q[i];
        end
      end
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign link.d_sda_o  = 1'b0;
  assign link.d_sda_oe = oe_q;
  assign busy          = busy_q;

endmodule // eep_dev

// ### design/eep_host.sv
// Host end of the two-wire link: byte-level bus master
`timescale 1ns/10ps
module eep_host
  import eep_pkg::*;
(
  input  wire logic    clk,                                   // System clock
  input  wire logic    resetn,                                // Async reset, active low
  input  wire logic    cmd_valid,                             // Command offered
  output logic         cmd_ready,                             // Command taken when high
  input  wire eep_op_t cmd_op,                                // Command kind
  input  wire logic [7:0] cmd_data,                           // Byte to send
  input  wire logic    cmd_mack,                              // Ack the byte read
  output logic         rsp_valid,                             // Command done pulse
  output logic [7:0]   rsp_data,                              // Byte read
  output logic         rsp_ack,                               // Ack seen on ninth bit
  eep_link_if.master   link                                   // Two-wire bus
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef enum logic [3:0] {
    M_IDLE  = 4'h1,                                           // Waiting for a command
    M_START = 4'h2,                                           // Making START
    M_BYTE  = 4'h4,                                           // Nine clock pulses
    M_STOP  = 4'h8                                            // Making STOP
  } eep_mst_t;

  eep_mst_t   st_q;                                           // Host state
  logic [3:0] qcnt_q;                                         // Quarter-bit timer
  logic [1:0] q_q;                                            // Quarter within bit
  logic [3:0] bit_q;                                          // Bit within byte
  logic [8:0] out_q;                                          // Bits to place, MSB first
  logic [8:0] in_q;                                           // Bits sampled
  logic       scl_q;                                          // Bus clock level
  logic       oe_q;                                           // Pulling SDA low
  logic [1:0] sda_sy_q;                                       // SDA sync
  logic       rv_q;                                           // Response pulse
  logic       tick;                                           // Quarter boundary
  logic       hold;                                           // Bus busy, wait

  assign tick = (qcnt_q == 4'h0);
  assign hold = (st_q == M_START) && (q_q == 2'h0) && scl_q && !sda_sy_q[1];

  // SDA sync, two flops
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sda_sy_q <= 2'h3;
    end else begin
      sda_sy_q <= {sda_sy_q[0], link.sda};
    end
  end

  // Quarter-bit divider, runs only while a command is active
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      qcnt_q <= 4'(SCL_QTR_CYC - 1);
    end else if ((st_q == M_IDLE) || tick) begin
      qcnt_q <= 4'(SCL_QTR_CYC - 1);
    end else begin
      qcnt_q <= qcnt_q - 4'h1;
    end
  end

  // ****************************************************************
  // Bus sequencer
  // ****************************************************************
  // Every command leaves SCL low except STOP, which leaves it high
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_q  <= M_IDLE;
      q_q   <= 2'h0;
      bit_q <= 4'h0;
      out_q <= 9'h1FF;
      in_q  <= 9'h000;
      scl_q <= 1'b1;
      oe_q  <= 1'b0;
      rv_q  <= 1'b0;
    end else begin
      rv_q <= 1'b0;
      unique case (st_q)
        M_IDLE: begin
          q_q   <= 2'h0;
          bit_q <= 4'h0;
          if (cmd_valid) begin
            unique case (cmd_op)
              OP_START: st_q <= M_START;
              OP_STOP:  st_q <= M_STOP;
              OP_WRITE: begin
                st_q  <= M_BYTE;
                out_q <= {cmd_data, 1'b1};                      // Release for slave ack
              end
              OP_READ: begin
                st_q  <= M_BYTE;
                out_q <= {8'hFF, ~cmd_mack};
              end
            endcase
          end
        end
        M_START: begin
          if (tick && !hold) begin
            q_q <= q_q + 2'h1;
            unique case (q_q)
              2'h0: oe_q  <= 1'b0;                              // Release before SCL is raised
              2'h1: scl_q <= 1'b1;
              2'h2: oe_q  <= 1'b1;
              2'h3: begin
                scl_q <= 1'b0;
                st_q  <= M_IDLE;
                rv_q  <= 1'b1;
              end
            endcase
          end
        end
        M_BYTE: begin
          if (tick) begin
            q_q <= q_q + 2'h1;
            unique case (q_q)
              2'h0: oe_q  <= ~out_q[8];
              2'h1: scl_q <= 1'b1;
              2'h2: ;
              2'h3: begin
                scl_q <= 1'b0;
                in_q  <= {in_q[7:0], sda_sy_q[1]};
                out_q <= {out_q[7:0], 1'b1};
                bit_q <= bit_q + 4'h1;
                if (bit_q == 4'h8) begin
                  st_q <= M_IDLE;
                  rv_q <= 1'b1;
                end
              end
            endcase
          end
        end
        M_STOP: begin
          if (tick) begin
            q_q <= q_q + 2'h1;
            unique case (q_q)
              2'h0: oe_q  <= 1'b1;
              2'h1: scl_q <= 1'b1;
              2'h2: oe_q  <= 1'b0;
              2'h3: begin
                st_q <= M_IDLE;
                rv_q <= 1'b1;
              end
            endcase
          end
        end
      endcase
    end
  end

  // Response capture on the ninth sample
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rsp_data <= 8'h00;
      rsp_ack  <= 1'b0;
    end else if ((st_q == M_BYTE) && tick && (q_q == 2'h3) && (bit_q == 4'h8)) begin
      rsp_data <= in_q[7:0];
      rsp_ack  <= ~sda_sy_q[1];
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign cmd_ready     = (st_q == M_IDLE);
  assign rsp_valid     = rv_q;
  assign link.scl      = scl_q;
  assign link.m_sda_o  = 1'b0;
  assign link.m_sda_oe = oe_q;

endmodule // eep_host

// ### design/eep_link_if.sv
// Two-wire link between the host end and the EEPROM end
`timescale 1ns/10ps
interface eep_link_if;
  logic scl;                                                  // Bus clock, host driven
  logic m_sda_o;                                              // Host data drive value
  logic m_sda_oe;                                             // Host pulls data line
  logic d_sda_o;                                              // Device data drive value
  logic d_sda_oe;                                             // Device pulls data line
  logic sda;                                                  // Resolved data line

  // Open-drain wire with pull-up
  assign sda = (m_sda_oe ? m_sda_o : 1'b1) & (d_sda_oe ? d_sda_o : 1'b1);

  modport master (output scl, output m_sda_o, output m_sda_oe, input sda);
  modport slave  (input scl, output d_sda_o, output d_sda_oe, input sda);
endinterface

// ### design/eep_pkg.sv
// Shared constants and types of the two-wire serial EEPROM link
package eep_pkg;

  // ****************************************************************
  // Clock and timing
  // ****************************************************************
  localparam int CLK_NS        = 5;                           // System clock period
  localparam int SCL_PERIOD_NS = 160;                         // Bus clock period made by host
  localparam int SCL_QTR_CYC   = SCL_PERIOD_NS / (4 * CLK_NS); // Cycles per quarter bit
  localparam int WR_TIME_NS    = 10_000_000;                  // Self-timed write length
  localparam int WR_CYC        = WR_TIME_NS / CLK_NS;         // Write length in cycles

  // ****************************************************************
  // Memory organisation
  // ****************************************************************
  localparam int ADDR_W     = 8;                              // Word address width
  localparam int MEM_DEPTH  = 256;                            // Bytes in the array
  localparam int PAGE_DEPTH = 8;                              // Page buffer entries
  localparam logic [7:0] PTR_RST  = 8'h00;                    // Pointer after reset
  localparam logic [3:0] DEV_CODE = 4'h6;                     // Device-type code, arbitrary

  // ****************************************************************
  // Host command set
  // ****************************************************************
  typedef enum logic [1:0] {
    OP_START = 2'h0,                                          // START or repeated START
    OP_STOP  = 2'h1,                                          // STOP
    OP_WRITE = 2'h2,                                          // Send a byte, read ack
    OP_READ  = 2'h3                                           // Read a byte, send ack
  } eep_op_t;

endpackage

// ### verification/eep_props.sv
// Wire-level checker for the two-wire EEPROM link
`timescale 1ns/10ps
module eep_props (
  input wire logic clk,      // System clock
  input wire logic resetn,   // Async reset, active low
  input wire logic busy,     // Device write cycle
  input wire logic scl,      // Bus clock
  input wire logic m_sda_oe, // Host pulls data
  input wire logic d_sda_o,  // Device drive value
  input wire logic d_sda_oe, // Device pulls data
  input wire logic sda       // Resolved data line
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // Write cycle holds a while, then ends within bound
  sequence s_wcyc;
    busy [*8] ##[1:1000] !busy;
  endsequence
  AST_NO_ACK_BUSY: assert property (busy && $past(busy) |-> !d_sda_oe)
    else $error("device drives data while busy");
  AST_DEV_STEADY: assert property (scl && $past(scl) |-> $stable(d_sda_oe))
    else $error("device data moved while clock high");
  AST_PULL_LOW: assert property (d_sda_oe |-> !d_sda_o && !sda)
    else $error("device drive is not a low pull");
  AST_START_IDLE: assert property (scl && $rose(m_sda_oe) |-> $past(sda))
    else $error("start without a high data line");
  AST_STOP_FREE: assert property (scl && $past(scl) && $fell(m_sda_oe) |-> !d_sda_oe)
    else $error("device holds data at stop");
  AST_SCL_HIGH: assert property ($rose(scl) |-> scl [*8])
    else $error("clock high phase too short");
  AST_WR_CYCLE: assert property ($rose(busy) |-> s_wcyc)
    else $error("write cycle length wrong");
  AST_BUSY_STOP: assert property ($rose(busy) |-> scl && sda && !m_sda_oe)
    else $error("write cycle without stop");
endmodule // eep_props

// ### verification/tb_top.sv
// Self-checking bench: host end drives the EEPROM end over the link
`timescale 1ns/10ps
module tb_top;
  import eep_pkg::*;
  localparam int WR_N = 900;        // Short write cycle
  localparam int LIMIT = 60000;     // Cycle ceiling
  logic       clk = 1'b0;           // System clock
  logic       resetn = 1'b0;        // Reset, active low
  logic       wp = 1'b0;            // Write protect
  logic       busy;                 // Write cycle running
  logic       cmd_valid = 1'b0;     // Command offered
  logic       cmd_ready;            // Host idle
  eep_op_t    cmd_op = OP_START;    // Command kind
  logic [7:0] cmd_data = 8'h00;     // Byte to send
  logic       cmd_mack = 1'b0;      // Ack the byte read
  logic       rsp_valid;            // Command done
  logic [7:0] rsp_data;             // Byte read
  logic       rsp_ack;              // Ack seen
  logic [8:0] sh = 9'h000;          // Last nine wire bits
  logic [7:0] pg [8];               // Expected page
  int         miscompares = 0;      // Mismatches
  int         n_checks = 0;         // Comparisons
  int         cyc = 0;              // Cycles run
  eep_link_if link ();
  eep_dev #(.WR_CYCLES(WR_N)) eep_dev_inst (.clk, .resetn, .wp, .busy, .link(link));
  eep_host eep_host_inst (.clk, .resetn, .cmd_valid, .cmd_ready, .cmd_op, .cmd_data,
    .cmd_mack, .rsp_valid, .rsp_data, .rsp_ack, .link(link));
  eep_props eep_props_inst (.clk, .resetn, .busy, .scl(link.scl), .m_sda_oe(link.m_sda_oe),
    .d_sda_o(link.d_sda_o), .d_sda_oe(link.d_sda_oe), .sda(link.sda));
  always #2.5 clk = ~clk;
  // Wire monitor: data sampled on clock rise
  always @(posedge link.scl) sh <= {sh[7:0], link.sda};
  // Hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      miscompares++;
      finish_test();
    end
  end
  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic finish_test();
    $display("checks=%0d mismatches=%0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // One host command, entered just after a clock edge
  task automatic cmd(input eep_op_t op, input logic [7:0] d, input logic mk);
    cmd_op <= op;
    cmd_data <= d;
    cmd_mack <= mk;
    cmd_valid <= 1'b1;
    do @(posedge clk); while (cmd_ready !== 1'b1);
    cmd_valid <= 1'b0;
    do @(posedge clk); while (rsp_valid !== 1'b1);
  endtask
  task automatic st();
    cmd(OP_START, 8'h00, 1'b0);
  endtask
  task automatic sp();
    cmd(OP_STOP, 8'h00, 1'b0);
  endtask
  task automatic wr(input logic [7:0] d, input logic a);
    cmd(OP_WRITE, d, 1'b0);
    chk({8'h00, rsp_ack}, {8'h00, a});
  endtask
  task automatic rd(input logic mk, input logic [7:0] e);
    cmd(OP_READ, 8'h00, mk);
    chk({1'b0, rsp_data}, {1'b0, e});
    chk(sh, {e, ~mk});
  endtask
  // Ack polling until the write cycle ends
  task automatic poll();
    int n;
    n = 0;
    do begin
      st();
      cmd(OP_WRITE, 8'h60, 1'b0);
      n++;
    end while (rsp_ack !== 1'b1 && n < 40);
    chk({8'h00, rsp_ack}, 9'h001);
  endtask
  initial begin
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    chk({7'h00, link.scl, link.sda}, 9'h003);
    // Byte write of location zero, read back later after the pointer wraps
    st();
    wr(8'h60, 1'b1);
    wr(8'h00, 1'b1);
    wr(8'h5C, 1'b1);
    sp();
    poll();
    st();
    wr(8'h50, 1'b0);
    sp();
    st();
    wr(8'h6A, 1'b1);
    wr(8'h15, 1'b1);
    for (int i = 0; i < 10; i++) begin
      pg[(5 + i) % 8] = 8'h30 + 8'(i);
      wr(8'h30 + 8'(i), 1'b1);
    end
    sp();
    chk({8'h00, busy}, 9'h001);
    st();
    wr(8'h60, 1'b0);
    poll();
    wr(8'h10, 1'b1);
    st();
    wr(8'h61, 1'b1);
    for (int j = 0; j < 7; j++) rd(j < 6, pg[j]);
    sp();
    st();
    wr(8'h61, 1'b1);
    rd(1'b0, pg[7]);
    sp();
    wp <= 1'b1;
    st();
    wr(8'h60, 1'b1);
    wr(8'h12, 1'b1);
    wr(8'hEE, 1'b1);
    sp();
    poll();
    wr(8'h12, 1'b1);
    st();
    wr(8'h61, 1'b1);
    rd(1'b0, pg[2]);
    sp();
    wp <= 1'b0;
    st();
    wr(8'h60, 1'b1);
    wr(8'hFF, 1'b1);
    wr(8'hA7, 1'b1);
    sp();
    poll();
    wr(8'hFF, 1'b1);
    st();
    wr(8'h61, 1'b1);
    rd(1'b1, 8'hA7);
    rd(1'b0, 8'h5C);
    sp();
    chk({7'h00, link.scl, link.sda}, 9'h003);
    finish_test();
  end
endmodule // tb_top
